// *** pkg/timer_x_pkg.sv ***
/*
  constants for the three-channel timer x block: register map, mode field
  layout, reset values and the clock divider counts.
  assumes an apb master running on pclk with 32-bit data.
*/
package timer_x_pkg;

  // =====================================================================
  // geometry
  localparam int NUM_CH = 3;
  localparam int CNT_W  = 16;

  // =====================================================================
  // register map, one word per register
  localparam logic [7:0] OFS_TIMER0 = 8'h00;
  localparam logic [7:0] OFS_TIMER1 = 8'h04;
  localparam logic [7:0] OFS_TIMER2 = 8'h08;
  localparam logic [7:0] OFS_MODE0  = 8'h10;
  localparam logic [7:0] OFS_MODE1  = 8'h14;
  localparam logic [7:0] OFS_MODE2  = 8'h18;
  localparam logic [7:0] OFS_START  = 8'h20; // bit i count start, channel i
  localparam logic [7:0] OFS_OSHOT  = 8'h24; // bit i one-shot start, write only
  localparam logic [7:0] OFS_STATUS = 8'h28; // [2:0] ovf flags, [6:4] irq, [10:8] pin

  // =====================================================================
  // mode register fields
  localparam int MD_MODE_LSB = 0;  // 2 bits
  localparam int MD_EDGE     = 2;  // 1 = falling edge active
  localparam int MD_PULSE    = 3;  // pulse output enable
  localparam int MD_FREERUN  = 4;  // event mode free run
  localparam int MD_WIDTH    = 5;  // 1 = width measurement
  localparam int MD_SRC_LSB  = 6;  // 2 bits: count clock or event source
  localparam int MD_OVF      = 8;  // read-only overflow flag position
  localparam int MD_W        = 8;
  localparam logic [MD_W-1:0]  MODE_RST  = 8'h00;
  localparam logic [CNT_W-1:0] TIMER_RST = 16'hFFFF;

  // =====================================================================
  // channel modes and event sources
  localparam logic [1:0] MODE_TIMER = 2'h0; // handled elsewhere, counter idles
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_OSHOT = 2'h2;
  localparam logic [1:0] MODE_MEAS  = 2'h3;
  localparam logic [1:0] SRC_PIN    = 2'h0;
  localparam logic [1:0] SRC_TB     = 2'h1;
  localparam logic [1:0] SRC_TA     = 2'h2;
  localparam logic [1:0] SRC_TX     = 2'h3;

  // =====================================================================
  // prescaler counts
  localparam int DIV_EIGHT      = 8;
  localparam int DIV_THIRTY_TWO = 32;

endpackage : timer_x_pkg

// *** tb/timer_x_event_oneshot_measure_bench.sv ***
/*
  self-checking bench for the three-channel timer block over apb.
  assumes the design package and the pin partner model are compiled first.
*/
`timescale 1ns/10ps
module timer_x_event_oneshot_measure_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, cap, start_v;
  logic        b_ovf, a_ovf, sub_tick;
  logic [4:0]  sub_div;
  logic [2:0]  pin_in, pin_out, pin_oe, irq;
  int          fail_count, compares, seed, n, p, e, base;
  int          irq_cnt [3];

  timer_x_event_oneshot_measure timer_x_event_oneshot_measure_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .second_b_timer_overflow(b_ovf),
    .first_a_timer_overflow(a_ovf), .sub_clock_div_thirty_two(sub_tick),
    .channel_io_pin_in(pin_in), .channel_io_pin_out(pin_out),
    .channel_io_pin_oe(pin_oe), .irq(irq));

  timer_x_pulse_partner timer_x_pulse_partner_inst (
    .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  // ======================================================================
  // clock, sub-clock tick and request counting
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // one-cycle tick every 32 clocks stands in for the slow clock
  always @(posedge pclk)
  begin
    sub_div <= sub_div + 5'h01;
    sub_tick <= (sub_div == 5'h1F);
    for (int i = 0; i < 3; i++)
      if (irq[i] === 1'b1) irq_cnt[i]++;
  end

  // ======================================================================
  // shared tasks
  task automatic chk(input bit ok, input string what);
    compares++;
    if (!ok)
      begin
        fail_count++;
        $display("BAD at %0t: %s", $time, what);
      end
  endtask : chk

  // one apb transfer; never assumes a latency, only a hang bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do
    begin
      @(posedge pclk);
      w++;
    end
    while (pready !== 1'b1 && w < 20);
    rd = prdata;
    err = pslverr;
    if (w >= 20) chk(1'b0, "no pready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one-cycle overflow strobe of the neighbouring timers, bit 1 b, bit 0 a
  task automatic ovf_pulse(input logic [1:0] w);
    @(posedge pclk);
    {b_ovf, a_ovf} <= w;
    @(posedge pclk);
    {b_ovf, a_ovf} <= 2'h0;
  endtask : ovf_pulse

  function automatic logic [31:0] md(input logic [1:0] m, input logic fe,
                                     input logic po, input logic fr,
                                     input logic [1:0] s);
    return {24'h000000, s, 1'b0, fr, po, fe, m};
  endfunction : md

  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // watchdog: the run needs about 66000 cycles, the overflow wait dominates
  initial
  begin
    #(90000 * 50);
    fail_count++;
    tally_and_finish();
  end

  // ======================================================================
  // main sequence
  initial
  begin
    seed = 32'hDCEDC325;
    {presetn, psel, penable, pwrite, b_ovf, a_ovf, sub_tick} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    sub_div = 5'h00;
    start_v = 32'h0;
    fail_count = 0;
    compares = 0;
    irq_cnt = '{0, 0, 0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and a refused address
    apb(1'b0, timer_x_pkg::OFS_MODE0, 32'h0);
    chk(rd === 32'h0, "mode reset");
    apb(1'b0, timer_x_pkg::OFS_STATUS, 32'h0);
    chk(rd === 32'h0, "status reset");
    apb(1'b1, 8'h3C, 32'h1);
    chk(err === 1'b1, "unmapped write");
    apb(1'b0, 8'h3C, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read");
    // channel 0 counts pin edges of a random polarity
    n = 3 + ($random(seed) & 7);
    e = $random(seed) & 1;
    apb(1'b1, timer_x_pkg::OFS_TIMER0, 32'(n));
    apb(1'b1, timer_x_pkg::OFS_MODE0, md(timer_x_pkg::MODE_EVENT, e[0], 1'b0, 1'b0,
        timer_x_pkg::SRC_PIN));
    start_v[0] = 1'b1;
    apb(1'b1, timer_x_pkg::OFS_START, start_v);
    timer_x_pulse_partner_inst.pulses(0, 2, 2);
    repeat (4) @(posedge pclk);
    apb(1'b0, timer_x_pkg::OFS_TIMER0, 32'h0);
    chk(rd === 32'(n - 2), "event count");
    timer_x_pulse_partner_inst.pulses(0, n - 1, 2);
    repeat (4) @(posedge pclk);
    apb(1'b0, timer_x_pkg::OFS_TIMER0, 32'h0);
    chk(rd === 32'(n) && irq_cnt[0] === 1, "divide by n plus one");
    start_v[0] = 1'b0;
    apb(1'b1, timer_x_pkg::OFS_START, start_v);
    timer_x_pulse_partner_inst.pulses(0, 2, 2);
    apb(1'b0, timer_x_pkg::OFS_TIMER0, 32'h0);
    chk(rd === 32'(n), "halted count");
    // channel 1 free-runs on the other timer's overflow with pulse output
    apb(1'b1, timer_x_pkg::OFS_TIMER1, 32'h1);
    apb(1'b1, timer_x_pkg::OFS_MODE1, md(timer_x_pkg::MODE_EVENT, 1'b0, 1'b1, 1'b1,
        timer_x_pkg::SRC_TA));
    start_v[1] = 1'b1;
    apb(1'b1, timer_x_pkg::OFS_START, start_v);
    chk(pin_oe[1] === 1'b1 && pin_out[1] === 1'b0, "pin driven");
    ovf_pulse(2'h2);
    ovf_pulse(2'h1);
    ovf_pulse(2'h1);
    repeat (4) @(posedge pclk);
    chk(irq_cnt[1] === 1 && pin_out[1] === 1'b1, "underflow toggle");
    apb(1'b0, timer_x_pkg::OFS_TIMER1, 32'h0);
    chk(rd === 32'h0000FFFF, "free run wrap");
    apb(1'b1, timer_x_pkg::OFS_TIMER1, 32'h5);
    apb(1'b0, timer_x_pkg::OFS_TIMER1, 32'h0);
    chk(rd === 32'h0000FFFF, "write while counting");
    // channel 2 one-shot on the undivided clock, then a retrigger
    n = 6 + ($random(seed) & 7);
    apb(1'b1, timer_x_pkg::OFS_TIMER2, 32'(n));
    apb(1'b1, timer_x_pkg::OFS_MODE2, md(timer_x_pkg::MODE_OSHOT, 1'b0, 1'b1, 1'b0,
        2'h0));
    start_v[2] = 1'b1;
    apb(1'b1, timer_x_pkg::OFS_START, start_v);
    apb(1'b1, timer_x_pkg::OFS_OSHOT, 32'h4);
    repeat (n - 3) @(posedge pclk);
    chk(irq_cnt[2] === 0 && pin_out[2] === 1'b1, "one-shot running");
    repeat (6) @(posedge pclk);
    chk(irq_cnt[2] === 1 && pin_out[2] === 1'b0, "one-shot done");
    apb(1'b1, timer_x_pkg::OFS_OSHOT, 32'h4);
    repeat (n - 5) @(posedge pclk);
    apb(1'b1, timer_x_pkg::OFS_OSHOT, 32'h4);
    repeat (4) @(posedge pclk);
    chk(irq_cnt[2] === 1, "retrigger reload");
    repeat (2 * n) @(posedge pclk);
    chk(irq_cnt[2] === 2, "one request then stop");
    // channel 0 measures a random period
    p = 8 + 2 * ($random(seed) & 7);
    apb(1'b1, timer_x_pkg::OFS_MODE0, md(timer_x_pkg::MODE_MEAS, 1'b0, 1'b0, 1'b0,
        2'h0));
    base = irq_cnt[0];
    start_v[0] = 1'b1;
    apb(1'b1, timer_x_pkg::OFS_START, start_v);
    timer_x_pulse_partner_inst.pulses(0, 3, p / 2);
    repeat (4) @(posedge pclk);
    chk(irq_cnt[0] === base + 2, "first edge silent");
    apb(1'b0, timer_x_pkg::OFS_TIMER0, 32'h0);
    cap = rd;
    chk(cap === 32'(p) || cap === 32'(p - 1), "period capture");
    apb(1'b1, timer_x_pkg::OFS_TIMER0, 32'h1234);
    apb(1'b0, timer_x_pkg::OFS_TIMER0, 32'h0);
    chk(rd === cap, "timer write ignored");
    repeat (65540) @(posedge pclk);
    apb(1'b0, timer_x_pkg::OFS_STATUS, 32'h0);
    chk(rd[0] === 1'b1 && irq_cnt[0] === base + 3, "overflow flag");
    apb(1'b1, timer_x_pkg::OFS_MODE0, md(timer_x_pkg::MODE_MEAS, 1'b0, 1'b0, 1'b0,
        2'h0));
    apb(1'b0, timer_x_pkg::OFS_STATUS, 32'h0);
    chk(rd[0] === 1'b0, "overflow flag cleared");
    // width measurement: both edges capture, last capture is the high time
    apb(1'b1, timer_x_pkg::OFS_MODE0, md(timer_x_pkg::MODE_MEAS, 1'b0, 1'b0, 1'b0,
        2'h0) | 32'h00000020);
    timer_x_pulse_partner_inst.pulses(0, 2, p / 2);
    repeat (4) @(posedge pclk);
    apb(1'b0, timer_x_pkg::OFS_TIMER0, 32'h0);
    chk(rd === 32'(p / 2), "width capture");
    tally_and_finish();
  end
endmodule : timer_x_event_oneshot_measure_bench

// *** tb/timer_x_pulse_partner.sv ***
/*
  far-side model of the three channel pins: a pulse source and a driven load.
  assumes the bench clock; the source changes only just after rising edges.
*/
`timescale 1ns/10ps
module timer_x_pulse_partner
(
  // clock
  input  wire logic       pclk,
  // device pin drivers
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  // level seen by the device
  output logic      [2:0] pin_in
);
  logic [2:0] src_q;

  // a driven pin reads back its own level, an undriven one shows the source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & src_q);

  initial src_q = 3'h0;

  // ======================================================================
  // pulse train
  // n pulses, high for half cycles then low for half cycles
  task automatic pulses(input int ch, input int n, input int half);
    for (int k = 0; k < n; k++)
    begin
      @(posedge pclk);
      src_q[ch] <= 1'b1;
      repeat (half) @(posedge pclk);
      src_q[ch] <= 1'b0;
      repeat (half - 1) @(posedge pclk);
    end
  endtask : pulses
endmodule : timer_x_pulse_partner

// *** verilog/timer_x_channel.sv ***
/*
  one timer x channel: counter, reload register, mode logic and pin.
  assumes ticks and overflow strobes are one-cycle pulses on pclk and the
  pin input is already synchronous to pclk.
*/
`timescale 1ns/10ps
module timer_x_channel
(
  // clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // control from the register file
  input  wire logic [timer_x_pkg::MD_W-1:0]   mode_q,
  input  wire logic                           start,
  input  wire logic                           oshot_set,
  input  wire logic                           timer_wr,
  input  wire logic [timer_x_pkg::CNT_W-1:0]  wdata,
  input  wire logic                           mode_wr,
  // count sources
  input  wire logic [3:0]                     clk_tick,
  input  wire logic [3:0]                     ovf_src,
  // pin
  input  wire logic                           pin_in,
  output logic                                pin_out,
  output logic                                pin_oe,
  // status
  output logic [timer_x_pkg::CNT_W-1:0]       read_val,
  output logic                                irq,
  output logic                                ovf_flag,
  output logic                                underflow
);

  // =====================================================================
  // decode of the mode register
  wire [1:0] mode     = mode_q[timer_x_pkg::MD_MODE_LSB +: 2];
  wire [1:0] src      = mode_q[timer_x_pkg::MD_SRC_LSB +: 2];
  wire       is_event = mode == timer_x_pkg::MODE_EVENT;
  wire       is_oshot = mode == timer_x_pkg::MODE_OSHOT;
  wire       is_meas  = mode == timer_x_pkg::MODE_MEAS;

  logic                            pin_q;
  logic                            pin_lvl_q;
  logic [timer_x_pkg::CNT_W-1:0]   cnt_q;
  logic [timer_x_pkg::CNT_W-1:0]   reload_q;
  logic                            run_q;
  logic                            first_q;
  logic                            irq_q;
  logic                            ovf_q;

  // active edge chosen by software; falling when the edge bit is set
  wire rise     = pin_in & ~pin_q;
  wire fall     = ~pin_in & pin_q;
  wire pin_edge = mode_q[timer_x_pkg::MD_EDGE] ? fall : rise;
  // width measurement sees both edges, one pulse from start to end
  wire meas_edge = mode_q[timer_x_pkg::MD_WIDTH] ? (rise | fall) : pin_edge;
  // a pin driven as pulse output must not feed back as its own count or trigger
  wire pin_ok   = ~mode_q[timer_x_pkg::MD_PULSE];
  wire ext_evt  = (src == timer_x_pkg::SRC_PIN) ? (pin_edge & pin_ok) : ovf_src[src];
  wire clk_evt  = clk_tick[src];

  // =====================================================================
  // per-mode step decode
  wire ev_step   = is_event & start & ext_evt;
  wire zero      = cnt_q == '0;
  wire ev_under  = ev_step & zero;
  wire os_trig   = is_oshot & start & (oshot_set | ext_evt);
  wire os_step   = is_oshot & start & run_q & clk_evt;
  wire os_zero   = os_step & (cnt_q == 16'h0001);
  wire ms_step   = is_meas & start & clk_evt;
  wire ms_ovf    = ms_step & (cnt_q == 16'hFFFF);
  wire ms_cap    = is_meas & start & meas_edge;
  // measurement mode refuses timer writes
  wire wr_ok     = timer_wr & ~is_meas;
  wire counting  = start & (~is_oshot | run_q);

  // =====================================================================
  // pin edge history and pulse-output level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_q     <= 1'b0;
      pin_lvl_q <= 1'b0;
    end
    else
    begin
      pin_q <= pin_in;
      if (ev_under & mode_q[timer_x_pkg::MD_PULSE])
        pin_lvl_q <= ~pin_lvl_q;
      else if (os_trig & mode_q[timer_x_pkg::MD_PULSE])
        pin_lvl_q <= 1'b1;
      else if (os_zero & mode_q[timer_x_pkg::MD_PULSE])
        pin_lvl_q <= 1'b0;
    end
  end

  // =====================================================================
  // counter and reload register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q    <= timer_x_pkg::TIMER_RST;
      reload_q <= timer_x_pkg::TIMER_RST;
    end
    else
    begin
      if (wr_ok)
        reload_q <= wdata;
      else if (ms_cap)
        reload_q <= ms_step ? cnt_q + 16'h0001 : cnt_q;
      if (wr_ok & ~counting)
        cnt_q <= wdata;
      else if (ms_cap)
        cnt_q <= '0;
      else if (ms_step)
        cnt_q <= cnt_q + 16'h0001;
      else if (ev_under & ~mode_q[timer_x_pkg::MD_FREERUN])
        cnt_q <= reload_q;
      else if (ev_step)
        cnt_q <= cnt_q - 16'h0001;
      else if (os_trig)
        cnt_q <= reload_q;
      else if (os_zero)
        cnt_q <= reload_q;
      else if (os_step)
        cnt_q <= cnt_q - 16'h0001;
    end
  end

  // =====================================================================
  // run state, first-edge mask, request and overflow flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q   <= 1'b0;
      first_q <= 1'b1;
      irq_q   <= 1'b0;
      ovf_q   <= 1'b0;
    end
    else
    begin
      if (!start | !is_oshot)
        run_q <= 1'b0;
      else if (os_trig)
        run_q <= 1'b1;
      else if (os_zero)
        run_q <= 1'b0;
      if (!start)
        first_q <= 1'b1;
      else if (ms_cap)
        first_q <= 1'b0;
      irq_q <= ev_under | os_zero | ms_ovf | (ms_cap & ~first_q);
      if (ms_ovf)
        ovf_q <= 1'b1;
      else if (mode_wr & start)
        ovf_q <= 1'b0;
    end
  end

  // =====================================================================
  // outputs; the pin is a driven output only with pulse output selected
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out   <= 1'b0;
      pin_oe    <= 1'b0;
      read_val  <= '0;
      underflow <= 1'b0;
    end
    else
    begin
      pin_out   <= pin_lvl_q;
      pin_oe    <= mode_q[timer_x_pkg::MD_PULSE] & (is_event | is_oshot);
      read_val  <= is_meas ? reload_q : (is_event ? cnt_q : 16'h0000);
      underflow <= ev_under | os_zero;
    end
  end

  assign irq      = irq_q;
  assign ovf_flag = ovf_q;

  AST_EV_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    ev_under |=> irq_q) else $error("event underflow gave no request");
  AST_EV_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
    ev_under && !wr_ok && !mode_q[timer_x_pkg::MD_FREERUN] |=> cnt_q == $past(reload_q))
    else $error("event underflow did not reload");
  AST_FREERUN: assert property (@(posedge pclk) disable iff (!presetn)
    ev_under && !wr_ok && mode_q[timer_x_pkg::MD_FREERUN] |=> cnt_q == 16'hFFFF)
    else $error("free run did not wrap");
  AST_STOP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !start && !timer_wr |=> cnt_q == $past(cnt_q)) else $error("counter moved while stopped");
  AST_OS_END: assert property (@(posedge pclk) disable iff (!presetn)
    os_zero && !os_trig |=> !run_q && irq_q) else $error("one-shot did not stop");
  AST_MEAS_CAP: assert property (@(posedge pclk) disable iff (!presetn)
    ms_cap |=> cnt_q == 16'h0000 && reload_q == $past(cnt_q) + {15'h0, $past(ms_step)})
    else $error("capture failed");
  AST_FIRST_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    ms_cap && first_q && !ms_ovf |=> !irq_q) else $error("first edge raised a request");
  AST_OVF_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    ms_ovf |=> ovf_q && irq_q) else $error("overflow flag not set");
  AST_MEAS_NOWR: assert property (@(posedge pclk) disable iff (!presetn)
    is_meas && timer_wr && !ms_cap |=> reload_q == $past(reload_q))
    else $error("measurement accepted a write");

endmodule : timer_x_channel

// *** verilog/timer_x_event_oneshot_measure.sv ***
/*
  apb-attached block of three timer x channels with shared prescaler.
  assumes an apb master on pclk, synchronous pin inputs and one-cycle
  overflow strobes from the neighbouring timers.
*/
`timescale 1ns/10ps
module timer_x_event_oneshot_measure
(
  // apb slave
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  // neighbouring timer overflow strobes
  input  wire logic         second_b_timer_overflow,
  input  wire logic         first_a_timer_overflow,
  // sub clock divided by thirty-two, one-cycle tick on pclk
  input  wire logic         sub_clock_div_thirty_two,
  // channel pins
  input  wire logic [2:0]   channel_io_pin_in,
  output logic [2:0]        channel_io_pin_out,
  output logic [2:0]        channel_io_pin_oe,
  // per-channel interrupt requests
  output logic [2:0]        irq
);

  // =====================================================================
  // apb decode; zero wait states, unmapped addresses answer with an error
  wire       access   = psel & penable;
  wire       wr       = access & pwrite;
  wire [7:0] a        = paddr;
  wire       hit_tmr  = a == timer_x_pkg::OFS_TIMER0 || a == timer_x_pkg::OFS_TIMER1 ||
                        a == timer_x_pkg::OFS_TIMER2;
  wire       hit_mode = a == timer_x_pkg::OFS_MODE0 || a == timer_x_pkg::OFS_MODE1 ||
                        a == timer_x_pkg::OFS_MODE2;
  wire       hit_misc = a == timer_x_pkg::OFS_START || a == timer_x_pkg::OFS_OSHOT ||
                        a == timer_x_pkg::OFS_STATUS;
  wire [1:0] idx      = a[3:2];
  wire       mapped   = (hit_tmr | hit_mode) ? (idx != 2'h3) : hit_misc;

  logic [timer_x_pkg::MD_W-1:0]  mode_q [timer_x_pkg::NUM_CH];
  logic [2:0]                    start_q;
  logic [4:0]                    div_q;
  logic [2:0]                    tick_q;
  logic [15:0]                   rval [timer_x_pkg::NUM_CH];
  logic [2:0]                    irq_w;
  logic [2:0]                    ovf_w;
  logic [2:0]                    under_w;
  logic [2:0]                    pin_o_w;
  logic [2:0]                    pin_e_w;
  logic [31:0]                   rd_d;

  // =====================================================================
  // prescaler: ticks for undivided, /8 and /32; the sub clock tick comes in on its own port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q  <= 5'h00;
      tick_q <= 3'h0;
    end
    else
    begin
      div_q  <= div_q + 5'h01;
      tick_q <= {div_q == 5'(timer_x_pkg::DIV_THIRTY_TWO - 1),
                 div_q[2:0] == 3'(timer_x_pkg::DIV_EIGHT - 1), 1'b1};
    end
  end
  wire main_clock_undivided     = tick_q[0];
  wire main_clock_div_eight     = tick_q[1];
  wire main_clock_div_thirty_two = tick_q[2];

  // =====================================================================
  // control registers written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < timer_x_pkg::NUM_CH; i++)
        mode_q[i] <= timer_x_pkg::MODE_RST;
      start_q <= 3'h0;
    end
    else if (wr && hit_mode && idx != 2'h3)
      mode_q[idx] <= pwdata[timer_x_pkg::MD_W-1:0];
    else if (wr && a == timer_x_pkg::OFS_START)
      start_q <= pwdata[2:0];
  end

  // =====================================================================
  // three identical channels
  genvar g;
  generate
    for (g = 0; g < timer_x_pkg::NUM_CH; g++)
    begin : gen_ch
      // sibling overflow is the next channel's underflow
      wire sibling_x_channel_overflow = under_w[(g + 1) % timer_x_pkg::NUM_CH];
      timer_x_channel u_ch
      (
        .pclk      (pclk),
        .presetn   (presetn),
        .mode_q    (mode_q[g]),
        .start     (start_q[g]),
        .oshot_set (wr && a == timer_x_pkg::OFS_OSHOT && pwdata[g]),
        .timer_wr  (wr && hit_tmr && idx == 2'(g)),
        .wdata     (pwdata[15:0]),
        .mode_wr   (wr && hit_mode && idx == 2'(g)),
        .clk_tick  ({sub_clock_div_thirty_two, main_clock_div_thirty_two,
                     main_clock_div_eight, main_clock_undivided}),
        .ovf_src   ({sibling_x_channel_overflow, first_a_timer_overflow,
                     second_b_timer_overflow, 1'b0}),
        .pin_in    (channel_io_pin_in[g]),
        .pin_out   (pin_o_w[g]),
        .pin_oe    (pin_e_w[g]),
        .read_val  (rval[g]),
        .irq       (irq_w[g]),
        .ovf_flag  (ovf_w[g]),
        .underflow (under_w[g])
      );
    end
  endgenerate

  // =====================================================================
  // read mux
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (hit_tmr && idx != 2'h3)
      rd_d = {16'h0000, rval[idx]};
    else if (hit_mode && idx != 2'h3)
      rd_d = {23'h0, ovf_w[idx], mode_q[idx]};
    else if (a == timer_x_pkg::OFS_START)
      rd_d = {29'h0, start_q};
    else if (a == timer_x_pkg::OFS_STATUS)
      rd_d = {21'h0, channel_io_pin_in, 1'b0, irq_w, 1'b0, ovf_w};
  end

  // =====================================================================
  // registered outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      irq     <= 3'h0;
      channel_io_pin_out <= 3'h0;
      channel_io_pin_oe  <= 3'h0;
    end
    else
    begin
      // answer in the cycle after setup; pready held one cycle only
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_d : 32'h0000_0000;
      irq     <= irq_w;
      channel_io_pin_out <= pin_o_w;
      channel_io_pin_oe  <= pin_e_w;
    end
  end

endmodule : timer_x_event_oneshot_measure
